// ### hw/clb_pkg.sv
// clb_pkg: shared constants for the local processor bus port
// assumes both ends and the testbench import it
package clb_pkg;
  localparam int CLB_DW = 32;
  localparam int CLB_LANES = 4;
  localparam int CLB_LANE_W = 8;
  localparam int CLB_HI_LSB = 4;
  localparam int CLB_LO_W = 2;
  localparam int CLB_LO_LSB = 2;
  localparam int CLB_ACK_WAIT = 1;
  localparam logic [CLB_DW-1:0] CLB_DATA_RST = 32'h0000_0000;
  localparam logic [CLB_DW-1:0] CLB_ERR_BASE = 32'hf000_0000;
  localparam logic [CLB_DW-1:0] CLB_ERR_MASK = 32'hf000_0000;
  localparam int CLB_INT_W = 4;
endpackage

// ### hw/clb_bus_if.sv
// clb_bus_if: wires of the multiplexed local bus between processor and controller
// assumes one clock shared by both ends; the shared bus level is resolved here
`timescale 1ns/100ps
interface clb_bus_if
  import clb_pkg::*;
  (input wire logic ref_clk, input wire logic rstn);
  logic [CLB_DW-1:0] ad_from_proc;
  logic ad_oe_proc;
  logic [CLB_DW-1:0] ad_from_ctl;
  logic ad_oe_ctl;
  logic [CLB_DW-1:0] ad;
  logic [CLB_LO_W-1:0] lo_addr;
  logic ale;
  logic cip_l;
  logic wr_l;
  logic [CLB_LANES-1:0] proc_byte_lane_enable_l;
  logic last_l;
  logic ack_l;
  logic buserr_l;
  assign ad = ad_oe_ctl ? ad_from_ctl : (ad_oe_proc ? ad_from_proc : CLB_DATA_RST);
  modport ctl (input ref_clk, rstn, ad, lo_addr, ale, cip_l, wr_l, proc_byte_lane_enable_l, last_l,
    output ad_from_ctl, ad_oe_ctl, ack_l, buserr_l);
  modport proc (input ref_clk, rstn, ad, ack_l, buserr_l,
    output ad_from_proc, ad_oe_proc, lo_addr, ale, cip_l, wr_l, proc_byte_lane_enable_l, last_l);
endinterface

// ### hw/clb_ctl_end.sv
// clb_ctl_end: controller end; latches address, acknowledges data, flags bus errors
// assumes inputs synchronous to ref_clk and one internal target word per lo address
// Function
// R01 - latch shared-bus address, drive outgoing address from it
// R02 - processor puts address 31:4 on bus
// R03 - processor drives write data after address
// R04 - dma or register read: no address, controller drives
// R05 - processor gives address 3:2 separately
// R06 - low address ignored during data phase
// R07 - address captured while latch strobe high
// R08 - cycle in progress low means transaction active
// R09 - write status low write, high read
// R10 - byte enables active low, one per lane
// R11 - enable 0 maps to bits 7:0
// R12 - acknowledge low when data word accepted
// R13 - last-data low marks final word
// R14 - bus error low on failed transfer
// R15 - enables 1..3 map to upper lanes ascending
`timescale 1ns/100ps
module clb_ctl_end
  import clb_pkg::*;
  (
  clb_bus_if.ctl bus,
  output logic [CLB_DW-1:0] mem_addr,
  output logic mem_addr_valid,
  output logic [CLB_DW-1:0] wr_data,
  output logic [CLB_LANES-1:0] wr_lane_en,
  output logic wr_strobe,
  output logic rd_strobe,
  input wire logic dma_drive,
  input wire logic [CLB_DW-1:0] dma_data,
  input wire logic dma_err
  );
  typedef enum logic [1:0] {CLB_IDLE = 2'b00, CLB_DATA = 2'b01, CLB_DONE = 2'b11} clb_state_e;
  // a slower target only needs a larger wait count; the beat logic stays as it is
  localparam int CLB_WAIT_W = (CLB_ACK_WAIT > 1) ? $clog2(CLB_ACK_WAIT) : 1;
  localparam logic [CLB_WAIT_W-1:0] CLB_WAIT_LAST = CLB_WAIT_W'(CLB_ACK_WAIT - 1);

  clb_state_e state_r, state_nxt;
  logic [CLB_DW-1:0] addr_r, addr_nxt;
  logic [CLB_WAIT_W-1:0] wait_r, wait_nxt;
  logic [CLB_DW-1:0] wdat_r, wdat_nxt;
  logic [CLB_LANES-1:0] wen_r, wen_nxt;
  logic wstb_r, wstb_nxt;
  logic rstb_r, rstb_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [CLB_DW-1:0] rdat_r, rdat_nxt;
  logic [CLB_DW-1:0] words [CLB_INT_W];
  logic [CLB_DW-1:0] rd_word;
  logic [CLB_LANES-1:0] lane_use;
  logic [CLB_LO_W-1:0] idx;
  logic [CLB_DW-1:0] addr_cap;
  logic addr_take;
  logic bad_addr;
  logic beat_go;
  logic wr_go;
  logic rd_go;

  // word index comes from the latch, so the low lines may change in the data phase
  assign idx = addr_r[CLB_LO_LSB +: CLB_LO_W]; // R06
  assign bad_addr = (addr_r & CLB_ERR_MASK) == CLB_ERR_BASE;
  assign lane_use = ~bus.proc_byte_lane_enable_l; // R10
  // high bits from the shared bus, 3:2 from the separate lines
  assign addr_cap = {bus.ad[CLB_DW-1:CLB_HI_LSB], bus.lo_addr, 2'h0}; // R01 R02 R05
  assign addr_take = (state_r == CLB_IDLE) && bus.ale && !bus.cip_l; // R07 R08
  assign beat_go = (state_r == CLB_DATA) && !bus.cip_l && !ack_r && (wait_r == CLB_WAIT_LAST); // R08 R12
  assign wr_go = beat_go && !bus.wr_l; // R09
  assign rd_go = beat_go && bus.wr_l; // R09
  assign rd_word = words[idx];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CLB_IDLE: begin
        if (addr_take) begin
          state_nxt = CLB_DATA;
        end
      end
      CLB_DATA: begin
        if (bus.cip_l) begin
          state_nxt = CLB_IDLE; // R08
        end else if (beat_go && !bus.last_l) begin
          state_nxt = CLB_DONE; // R13
        end
      end
      CLB_DONE: begin
        if (bus.cip_l) begin
          state_nxt = CLB_IDLE; // R08
        end
      end
      default: state_nxt = CLB_IDLE;
    endcase
  end
  always_ff @(posedge bus.ref_clk or negedge bus.rstn) begin
    if (!bus.rstn) begin
      state_r <= CLB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    addr_nxt = addr_r;
    if (addr_take) begin
      addr_nxt = addr_cap; // R01
    end else if ((state_r == CLB_DATA) && !bus.cip_l && ack_r) begin
      // burst without last: the next word of the line follows
      addr_nxt = addr_r + 32'h0000_0004;
    end
  end
  always_ff @(posedge bus.ref_clk or negedge bus.rstn) begin
    if (!bus.rstn) begin
      addr_r <= CLB_DATA_RST;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  always_comb begin
    wait_nxt = '0;
    if ((state_r == CLB_DATA) && !bus.cip_l && !ack_r && !beat_go) begin
      wait_nxt = wait_r + CLB_WAIT_W'(1);
    end
  end
  always_ff @(posedge bus.ref_clk or negedge bus.rstn) begin
    if (!bus.rstn) begin
      wait_r <= '0;
    end else begin
      wait_r <= wait_nxt;
    end
  end

  always_comb begin
    ack_nxt = beat_go; // R12
    err_nxt = dma_err | (beat_go & bad_addr); // R14
    wstb_nxt = wr_go;
    rstb_nxt = rd_go;
  end
  always_ff @(posedge bus.ref_clk or negedge bus.rstn) begin
    if (!bus.rstn) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      wstb_r <= 1'b0;
      rstb_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      wstb_r <= wstb_nxt;
      rstb_r <= rstb_nxt;
    end
  end

  always_comb begin
    wdat_nxt = wdat_r;
    wen_nxt = wen_r;
    rdat_nxt = rdat_r;
    if (wr_go) begin
      wdat_nxt = bus.ad; // R03
      wen_nxt = lane_use; // R10
    end
    if (rd_go) begin
      rdat_nxt = rd_word;
    end
  end
  always_ff @(posedge bus.ref_clk or negedge bus.rstn) begin
    if (!bus.rstn) begin
      wdat_r <= CLB_DATA_RST;
      wen_r <= '0;
      rdat_r <= CLB_DATA_RST;
    end else begin
      wdat_r <= wdat_nxt;
      wen_r <= wen_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  generate
    for (genvar e = 0; e < CLB_INT_W; e++) begin : g_word
      logic [CLB_DW-1:0] word_r, word_nxt;
      logic hit;
      assign hit = wr_go && (idx == CLB_LO_W'(e));
      assign words[e] = word_r;
      always_comb begin
        word_nxt = word_r;
        for (int i = 0; i < CLB_LANES; i++) begin
          // lane i is bits 8i+7:8i whatever the endianness
          if (hit && lane_use[i]) begin
            word_nxt[i*CLB_LANE_W +: CLB_LANE_W] = bus.ad[i*CLB_LANE_W +: CLB_LANE_W]; // R11 R15
          end
        end
      end
      always_ff @(posedge bus.ref_clk or negedge bus.rstn) begin
        if (!bus.rstn) begin
          word_r <= CLB_DATA_RST;
        end else begin
          word_r <= word_nxt;
        end
      end
    end
  endgenerate

  assign mem_addr = addr_r; // R01
  assign mem_addr_valid = (state_r != CLB_IDLE);
  assign wr_data = wdat_r;
  assign wr_lane_en = wen_r;
  assign wr_strobe = wstb_r;
  assign rd_strobe = rstb_r;
  assign bus.ack_l = ~ack_r; // R12
  assign bus.buserr_l = ~err_r; // R14
  // read data stands while ack is low; dma writes need no address phase
  assign bus.ad_oe_ctl = dma_drive | (rstb_r & ack_r); // R04
  assign bus.ad_from_ctl = dma_drive ? dma_data : rdat_r; // R04
endmodule

// ### hw/clb_proc_end.sv
// clb_proc_end: processor end; runs single-word reads and writes on the local bus
// assumes the controller answers with ack within a bounded time
`timescale 1ns/100ps
module clb_proc_end
  import clb_pkg::*;
  (
  clb_bus_if.proc bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic [CLB_DW-1:0] req_addr,
  input wire logic [CLB_DW-1:0] req_wdata,
  input wire logic [CLB_LANES-1:0] req_lanes,
  output logic req_ready,
  output logic [CLB_DW-1:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_err
  );
  typedef enum logic [1:0] {CLB_P_IDLE = 2'b00, CLB_P_ADDR = 2'b01, CLB_P_DATA = 2'b11, CLB_P_END = 2'b10}
    clb_pstate_e;
  clb_pstate_e st_r, st_nxt;
  logic [CLB_DW-1:0] a_r, a_nxt, d_r, d_nxt, rd_r, rd_nxt;
  logic [CLB_LANES-1:0] be_r, be_nxt;
  logic wr_r, wr_nxt, rv_r, rv_nxt, re_r, re_nxt;
  always_comb begin
    st_nxt = st_r;
    a_nxt = a_r;
    d_nxt = d_r;
    be_nxt = be_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    rv_nxt = 1'b0;
    re_nxt = re_r;
    unique case (st_r)
      CLB_P_IDLE: if (req) begin
        a_nxt = req_addr;
        d_nxt = req_wdata;
        be_nxt = req_lanes;
        wr_nxt = req_write;
        st_nxt = CLB_P_ADDR;
      end
      CLB_P_ADDR: st_nxt = CLB_P_DATA;
      CLB_P_DATA: if (!bus.ack_l) begin
        rd_nxt = bus.ad;
        rv_nxt = 1'b1;
        re_nxt = !bus.buserr_l;
        st_nxt = CLB_P_END;
      end
      CLB_P_END: st_nxt = CLB_P_IDLE;
    endcase
  end
  always_ff @(posedge bus.ref_clk or negedge bus.rstn) begin
    if (!bus.rstn) begin
      st_r <= CLB_P_IDLE;
      a_r <= CLB_DATA_RST;
      d_r <= CLB_DATA_RST;
      be_r <= '0;
      wr_r <= 1'b0;
      rd_r <= CLB_DATA_RST;
      rv_r <= 1'b0;
      re_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      be_r <= be_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      rv_r <= rv_nxt;
      re_r <= re_nxt;
    end
  end
  assign req_ready = (st_r == CLB_P_IDLE);
  assign bus.ale = (st_r == CLB_P_ADDR); // R07
  assign bus.cip_l = !(st_r == CLB_P_ADDR || st_r == CLB_P_DATA); // R08
  assign bus.wr_l = !wr_r; // R09
  assign bus.lo_addr = a_r[CLB_LO_LSB +: CLB_LO_W]; // R05
  assign bus.proc_byte_lane_enable_l = (st_r == CLB_P_DATA) ? ~be_r : '1; // R10
  assign bus.last_l = !(st_r == CLB_P_DATA); // R13
  // address phase drives 31:4 only; write data follows in the data phase
  assign bus.ad_oe_proc = (st_r == CLB_P_ADDR) || (st_r == CLB_P_DATA && wr_r); // R02 R03
  assign bus.ad_from_proc = (st_r == CLB_P_ADDR) ? {a_r[CLB_DW-1:CLB_HI_LSB], 4'h0} : d_r; // R02 R03
  assign rsp_data = rd_r;
  assign rsp_valid = rv_r;
  assign rsp_err = re_r;
endmodule

// ### test/clb_bus_checker.sv
// clb_bus_checker: timing relations on the local bus wires
// assumes it sits beside the bus interface, all signals on ref_clk
`timescale 1ns/100ps
module clb_bus_checker
  import clb_pkg::*;
  (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ad_oe_proc,
  input wire logic ad_oe_ctl,
  input wire logic ale,
  input wire logic cip_l,
  input wire logic wr_l,
  input wire logic last_l,
  input wire logic ack_l,
  input wire logic buserr_l
  );
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  addr_answer_a: assert property (ale && !cip_l |-> ##2 (!ack_l || !buserr_l)) else $error("no answer after ale");
  ack_pulse_a: assert property (!ack_l |=> ack_l) else $error("ack longer than a cycle");
  err_pulse_a: assert property (!buserr_l |=> buserr_l) else $error("bus error too long");
  ack_in_cycle_a: assert property (!ack_l |-> !cip_l) else $error("ack outside a cycle");
  read_drive_a: assert property (!ack_l && wr_l && buserr_l |-> ad_oe_ctl) else $error("read data not driven");
  write_quiet_a: assert property (!wr_l && !cip_l |-> !ad_oe_ctl) else $error("ctl drives on write");
  ale_drive_a: assert property (ale |-> ad_oe_proc && !cip_l) else $error("ale without address");
  last_word_a: assert property (!ack_l |-> !last_l) else $error("single word not marked last");
  // single-word traffic only, so last is expected low at every ack
  wr_ack_c: cover property (!ack_l && !wr_l);
  rd_ack_c: cover property (!ack_l && wr_l);
  err_c: cover property (!buserr_l);
endmodule

// ### test/testbench.sv
// testbench: processor end and controller end joined by the bus interface
// assumes single-word transfers; expected words come from a four-word mirror
`timescale 1ns/100ps
module testbench;
  import clb_pkg::*;
  logic ref_clk, rstn, req, req_write, req_ready, rsp_valid, rsp_err;
  logic mem_addr_valid, wr_strobe, rd_strobe, dma_drive, dma_err;
  logic [CLB_DW-1:0] req_addr, req_wdata, rsp_data, mem_addr, wr_data, dma_data;
  logic [CLB_LANES-1:0] req_lanes, wr_lane_en;
  logic [CLB_DW-1:0] mdl [4];
  int mismatches, samples_checked;
  clb_bus_if bus (.ref_clk(ref_clk), .rstn(rstn));
  clb_ctl_end i_clb_ctl_end (.bus(bus), .mem_addr(mem_addr), .mem_addr_valid(mem_addr_valid), .wr_data(wr_data),
    .wr_lane_en(wr_lane_en), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .dma_drive(dma_drive),
    .dma_data(dma_data), .dma_err(dma_err));
  clb_proc_end i_clb_proc_end (.bus(bus), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .req_ready(req_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err));
  clb_bus_checker i_clb_bus_checker (.ref_clk(ref_clk), .rstn(rstn), .ad_oe_proc(bus.ad_oe_proc),
    .ad_oe_ctl(bus.ad_oe_ctl), .ale(bus.ale), .cip_l(bus.cip_l), .wr_l(bus.wr_l), .last_l(bus.last_l),
    .ack_l(bus.ack_l), .buserr_l(bus.buserr_l));
  task automatic check(input logic [CLB_DW-1:0] seen, input logic [CLB_DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait: a hang becomes a mismatch and ends the run
  task automatic tick(inout int n);
    @(posedge ref_clk);
    #1;
    n++;
    if (n > 40) begin
      mismatches++;
      close_out();
    end
  endtask
  function automatic logic [CLB_DW-1:0] merge(input logic [CLB_DW-1:0] o, input logic [CLB_DW-1:0] d,
    input logic [CLB_LANES-1:0] ln);
    merge = o;
    for (int i = 0; i < CLB_LANES; i++) if (ln[i]) merge[i*CLB_LANE_W +: CLB_LANE_W] = d[i*CLB_LANE_W +: CLB_LANE_W];
  endfunction
  task automatic xfer(input logic w, input logic [CLB_DW-1:0] a, input logic [CLB_DW-1:0] d,
    input logic [CLB_LANES-1:0] ln);
    int n;
    int strobes;
    n = 0;
    strobes = 0;
    @(posedge ref_clk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= ln;
    #1;
    while (req_ready !== 1'b1) tick(n);
    @(posedge ref_clk);
    req <= 1'b0;
    while (rsp_valid !== 1'b1) begin
      tick(n);
      if (wr_strobe === 1'b1 || rd_strobe === 1'b1) begin
        strobes++;
        check({31'h0, wr_strobe}, {31'h0, w});
        check({31'h0, mem_addr_valid}, 32'h1);
        check(mem_addr, a);
      end
      if (wr_strobe === 1'b1) begin
        check(wr_data, d);
        check({28'h0, wr_lane_en}, {28'h0, ln});
      end
    end
    check(strobes, 32'h1);
    if ((a & CLB_ERR_MASK) == CLB_ERR_BASE) check({31'h0, rsp_err}, 32'h1);
    else begin
      if (w) mdl[a[3:2]] = merge(mdl[a[3:2]], d, ln);
      check({31'h0, rsp_err}, 32'h0);
      if (!w) check(rsp_data, mdl[a[3:2]]);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    rstn = 1'b0;
    {req, req_write, dma_drive, dma_err} = 4'h0;
    {req_addr, req_wdata, dma_data} = '0;
    req_lanes = 4'h0;
    mdl = '{default: '0};
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'hee64));
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    // one lane at a time pins each enable to its own byte
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 32'h0000_1000 | (k << 2), 32'h8877_6655 + k, 4'h1 << k);
      xfer(1'b0, 32'h0000_1000 | (k << 2), 32'h0, 4'hf);
    end
    $display("test lanes done");
    repeat (40) xfer(1'($urandom_range(1, 0)), $urandom & 32'h7fff_fffc, $urandom, 4'($urandom_range(15, 1)));
    $display("test random done");
    // error read followed at once by a clean read clears the error
    xfer(1'b0, CLB_ERR_BASE | 32'h8, 32'h0, 4'hf);
    xfer(1'b0, 32'h0000_0008, 32'h0, 4'hf);
    $display("test error done");
    @(posedge ref_clk);
    dma_drive <= 1'b1;
    dma_data <= $urandom;
    dma_err <= 1'b1;
    @(posedge ref_clk);
    dma_err <= 1'b0;
    #1;
    check(bus.ad, dma_data);
    check({31'h0, bus.buserr_l}, 32'h0);
    @(posedge ref_clk);
    dma_drive <= 1'b0;
    $display("test dma done");
    // reset in mid-run clears the stored words and a pending error
    xfer(1'b0, CLB_ERR_BASE | 32'h4, 32'h0, 4'hf);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({30'h0, bus.ack_l, bus.buserr_l}, 32'h3);
    check({31'h0, rsp_err}, 32'h0);
    check({31'h0, bus.cip_l}, 32'h1);
    @(posedge ref_clk);
    rstn <= 1'b1;
    mdl = '{default: CLB_DATA_RST};
    for (int k = 0; k < 4; k++) xfer(1'b0, k << 2, 32'h0, 4'hf);
    $display("test reset done");
    repeat (4) @(posedge ref_clk);
    close_out();
  end
endmodule
